// *** common/fcd_defs.svh ***
/*
 * Timing counts, field positions and reset values for the flow-and-compare
 * executor. Assumes it is included by bare name from packages and modules.
 */
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH

// -----------------------------------------------------------------------
// Widths and reset value
// -----------------------------------------------------------------------
`define FCD_PC_W 22
`define FCD_RA_BYTES 3
`define FCD_SP_RESET 16'hFFFF

// -----------------------------------------------------------------------
// Cycle counts per instruction
// -----------------------------------------------------------------------
`define FCD_CYC_SEQ 1
`define FCD_CYC_REL_JUMP 2
`define FCD_CYC_PTR_JUMP 2
`define FCD_CYC_ABS_JUMP 3
`define FCD_CYC_CALL 4
`define FCD_CYC_ABS_CALL 5
`define FCD_CYC_EXIT 5
`define FCD_CYC_BRANCH 2
`define FCD_SKIP_SHORT 2
`define FCD_SKIP_LONG 3

// -----------------------------------------------------------------------
// Status register bit positions
// -----------------------------------------------------------------------
`define FCD_SR_I 7
`define FCD_SR_H 5
`define FCD_SR_V 3
`define FCD_SR_N 2
`define FCD_SR_Z 1
`define FCD_SR_C 0

`endif

// *** common/fcd_pkg.sv ***
/*
 * Types for the flow-and-compare executor.
 * Assumes fcd_defs.svh is on the include path.
 */
`default_nettype none

`include "fcd_defs.svh"

package fcd_pkg;

    // -------------------------------------------------------------------
    // Operation selected by the decoder in front of this block
    // -------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE,
        OP_ABSOLUTE_JUMP,
        OP_RELATIVE_JUMP,
        OP_POINTER_JUMP,
        OP_EXTENDED_POINTER_JUMP,
        OP_RELATIVE_SUBROUTINE_BRANCH,
        OP_POINTER_SUBROUTINE_BRANCH,
        OP_EXTENDED_POINTER_SUBROUTINE_BRANCH,
        OP_ABSOLUTE_SUBROUTINE_BRANCH,
        OP_SUBROUTINE_EXIT,
        OP_INTERRUPT_EXIT,
        OP_COMPARE_SKIP_EQUAL,
        OP_COMPARE_REGS,
        OP_COMPARE_WITH_BORROW,
        OP_COMPARE_IMMEDIATE,
        OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_REG_BIT_ONE,
        OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_ONE,
        OP_BRANCH_FLAG_ONE
    } fcd_op_t;

    // Sequencer states.
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_EXEC
    } fcd_state_t;

endpackage : fcd_pkg

`default_nettype wire

// *** common/fcd_cmp_if.sv ***
/*
 * Carrier between the executor and its compare unit.
 * Assumes one producer of operands and one flag calculator.
 */
`timescale 1ns/1ps
`default_nettype none

interface fcd_cmp_if;
    logic [7:0] a; // Minuend.
    logic [7:0] b; // Subtrahend.
    logic cin; // Borrow in.
    logic use_cin; // Chained compare.
    logic z_in; // Previous zero flag.
    logic h, v, n, z, c; // Resulting flags.

    modport ctl (output a, b, cin, use_cin, z_in, input h, v, n, z, c);
    modport unit (input a, b, cin, use_cin, z_in, output h, v, n, z, c);
endinterface : fcd_cmp_if

`default_nettype wire

// *** src/fcd_cmp.sv ***
/*
 * Eight-bit compare unit: subtracts without a result and reports flags.
 * Assumes operands are stable in the cycle the flags are sampled.
 */
`timescale 1ns/1ps
`default_nettype none

module fcd_cmp import fcd_pkg::*; (
    fcd_cmp_if.unit cmp
);

    logic [7:0] r; // Difference, never written back.
    logic bin; // Effective borrow in.

    // -------------------------------------------------------------------
    // Subtraction and flags
    // -------------------------------------------------------------------
    always_comb begin
        bin = cmp.use_cin & cmp.cin;
        r = cmp.a - cmp.b - {7'h00, bin};
        cmp.c = (~cmp.a[7] & cmp.b[7]) | (cmp.b[7] & r[7]) | (r[7] & ~cmp.a[7]);
        cmp.h = (~cmp.a[3] & cmp.b[3]) | (cmp.b[3] & r[3]) | (r[3] & ~cmp.a[3]);
        cmp.v = (cmp.a[7] & ~cmp.b[7] & ~r[7]) | (~cmp.a[7] & cmp.b[7] & r[7]);
        cmp.n = r[7];
        // A chained compare keeps zero only if every stage was zero, so
        // multi-byte compares report equality across the whole word.
        if (cmp.use_cin) begin
            cmp.z = (r == 8'h00) & cmp.z_in;
        end else begin
            cmp.z = (r == 8'h00);
        end
    end

endmodule : fcd_cmp

`default_nettype wire

// *** src/fcd_core.sv ***
/*
 * Executor for jumps, subroutine branches, exits, compares, skips and
 * flag branches of an 8-bit core. Holds program counter, stack pointer
 * and status register. Assumes a decoder presents one operation with
 * start, and a byte-wide stack memory that writes on the clock and reads
 * combinationally.
 */
`timescale 1ns/1ps
`default_nettype none

`include "fcd_defs.svh"

// Notes on behaviour
// - Pointer call pushes return, loads pointer, four.
// - Extended call target is prefix above pointer.
// - Absolute call pushes return, loads immediate target.
// - Interrupt exit pops PC, sets I flag.
// - Equal registers skip next instruction, flags kept.
// - Compares subtract silently, update Z N V C H.
// - Register bit test skips on match.
// - Clear I/O bit skips next instruction.
// - Set I/O bit skips next instruction.
// - Set status flag branches to PC+k+1.
module fcd_core import fcd_pkg::*; #(
    parameter int PC_W = `FCD_PC_W,
    parameter logic [15:0] SP_RESET = `FCD_SP_RESET
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire fcd_op_t op,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] rr_val,
    input wire logic [7:0] imm_val,
    input wire logic [11:0] rel_ofs,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] io_val,
    input wire logic next_two_word,
    input wire logic [15:0] ptr_val,
    input wire logic [7:0] extended_pointer_prefix,
    input wire logic [PC_W-1:0] abs_target,
    input wire logic [7:0] stk_rdata,
    output logic busy,
    output logic done,
    output logic [PC_W-1:0] pc_q,
    output logic [7:0] status_register,
    output logic [15:0] sp_q,
    output logic [15:0] stk_addr,
    output logic stk_we,
    output logic [7:0] stk_wdata,
    output logic stk_re
);

    localparam int RA_W = 8 * `FCD_RA_BYTES; // Stacked address width.

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // PC plus signed offset plus one, shared by relative jump, relative call and flag branch.
    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                   input logic [11:0] ofs);
        logic [PC_W-1:0] ext;
        ext = PC_W'($signed(ofs));
        return pc + ext + PC_W'(1);
    endfunction : rel_target

    // Words to advance when skipping.
    function automatic logic [2:0] skip_amt(input logic two_word);
        return two_word ? 3'(`FCD_SKIP_LONG) : 3'(`FCD_SKIP_SHORT);
    endfunction : skip_amt

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    fcd_state_t st_q, st_d; // Sequencer.
    fcd_op_t op_q, op_d; // Operation in progress.
    logic [2:0] cnt_q, cnt_d; // Cycles left after this one.
    logic [1:0] idx_q, idx_d; // Stack byte index.
    logic [RA_W-1:0] tgt_q, tgt_d; // Next PC, assembled on pops.
    logic [RA_W-1:0] ret_q, ret_d; // Return address to push.
    logic [PC_W-1:0] pc_d;
    logic [7:0] sr_q, sr_d; // Status register.
    logic [15:0] sp_d;

    // Start-cycle scratch.
    logic [PC_W-1:0] tgt; // Target of the new operation.
    logic [PC_W-1:0] ret; // Return address of the new operation.
    logic [2:0] cyc; // Total cycles of the new operation.
    logic is_call, is_exit;
    logic skip; // Skip condition true.

    fcd_cmp_if cmp ();

    fcd_cmp u_cmp (
        .cmp(cmp.unit)
    );

    assign busy = (st_q == ST_EXEC);
    assign status_register = sr_q;

    // -------------------------------------------------------------------
    // Compare operands
    // -------------------------------------------------------------------
    always_comb begin
        cmp.a = rd_val;
        cmp.b = (op == OP_COMPARE_IMMEDIATE) ? imm_val : rr_val;
        cmp.cin = sr_q[`FCD_SR_C];
        cmp.use_cin = (op == OP_COMPARE_WITH_BORROW);
        cmp.z_in = sr_q[`FCD_SR_Z];
    end

    // -------------------------------------------------------------------
    // Decode of a newly started operation
    // -------------------------------------------------------------------
    always_comb begin
        tgt = pc_q + PC_W'(1);
        ret = pc_q + PC_W'(1);
        cyc = 3'(`FCD_CYC_SEQ);
        is_call = 1'b0;
        is_exit = 1'b0;
        skip = 1'b0;
        case (op)
            OP_ABSOLUTE_JUMP: begin
                tgt = abs_target;
                cyc = 3'(`FCD_CYC_ABS_JUMP);
            end
            OP_RELATIVE_JUMP: begin
                tgt = rel_target(pc_q, rel_ofs);
                cyc = 3'(`FCD_CYC_REL_JUMP);
            end
            OP_POINTER_JUMP: begin
                tgt = PC_W'(ptr_val);
                cyc = 3'(`FCD_CYC_PTR_JUMP);
            end
            OP_EXTENDED_POINTER_JUMP: begin
                tgt = PC_W'({extended_pointer_prefix, ptr_val});
                cyc = 3'(`FCD_CYC_PTR_JUMP);
            end
            OP_RELATIVE_SUBROUTINE_BRANCH: begin
                tgt = rel_target(pc_q, rel_ofs);
                cyc = 3'(`FCD_CYC_CALL);
                is_call = 1'b1;
            end
            OP_POINTER_SUBROUTINE_BRANCH: begin
                tgt = PC_W'(ptr_val);
                cyc = 3'(`FCD_CYC_CALL);
                is_call = 1'b1;
            end
            OP_EXTENDED_POINTER_SUBROUTINE_BRANCH: begin
                // Prefix bits beyond the PC width are dropped on purpose.
                tgt = PC_W'({extended_pointer_prefix, ptr_val});
                cyc = 3'(`FCD_CYC_CALL);
                is_call = 1'b1;
            end
            OP_ABSOLUTE_SUBROUTINE_BRANCH: begin
                tgt = abs_target;
                ret = pc_q + PC_W'(2); // Two-word instruction.
                cyc = 3'(`FCD_CYC_ABS_CALL);
                is_call = 1'b1;
            end
            OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
                cyc = 3'(`FCD_CYC_EXIT);
                is_exit = 1'b1;
            end
            OP_COMPARE_SKIP_EQUAL: skip = (rd_val == rr_val);
            OP_SKIP_REG_BIT_CLEAR: skip = ~rr_val[bit_sel];
            OP_SKIP_REG_BIT_ONE: skip = rr_val[bit_sel];
            OP_SKIP_IO_BIT_CLEAR: skip = ~io_val[bit_sel];
            OP_SKIP_IO_BIT_ONE: skip = io_val[bit_sel];
            OP_BRANCH_FLAG_ONE: begin
                // Not taken falls through to the sequential address.
                if (sr_q[bit_sel]) begin
                    tgt = rel_target(pc_q, rel_ofs);
                    cyc = 3'(`FCD_CYC_BRANCH);
                end
            end
            default: begin
                cyc = 3'(`FCD_CYC_SEQ);
            end
        endcase
        if (skip) begin
            tgt = pc_q + PC_W'(skip_amt(next_two_word));
            cyc = skip_amt(next_two_word);
        end
    end

    // -------------------------------------------------------------------
    // Sequencer next state
    // -------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        tgt_d = tgt_q;
        ret_d = ret_q;
        pc_d = pc_q;
        sr_d = sr_q;
        sp_d = sp_q;
        done = 1'b0;
        stk_we = 1'b0;
        stk_re = 1'b0;
        stk_wdata = 8'h00;
        stk_addr = sp_q;
        case (st_q)
            ST_IDLE: begin
                if (start) begin
                    // Only the compares touch flags at start; flow ops keep them, save the I flag that interrupt exit sets when done.
                    if (op == OP_COMPARE_REGS || op == OP_COMPARE_WITH_BORROW ||
                        op == OP_COMPARE_IMMEDIATE) begin
                        sr_d[`FCD_SR_Z] = cmp.z;
                        sr_d[`FCD_SR_N] = cmp.n;
                        sr_d[`FCD_SR_V] = cmp.v;
                        sr_d[`FCD_SR_C] = cmp.c;
                        sr_d[`FCD_SR_H] = cmp.h;
                    end
                    if (cyc == 3'(`FCD_CYC_SEQ)) begin
                        pc_d = tgt;
                        done = 1'b1;
                    end else begin
                        st_d = ST_EXEC;
                        op_d = op;
                        cnt_d = cyc - 3'd2;
                        idx_d = 2'd0;
                        tgt_d = RA_W'(tgt);
                        ret_d = is_call ? RA_W'(ret) : '0;
                        // Exits rebuild the target from the stack.
                        if (is_exit) begin
                            tgt_d = '0;
                        end
                    end
                end
            end
            ST_EXEC: begin
                if (idx_q < 2'(`FCD_RA_BYTES)) begin
                    if (op_q == OP_RELATIVE_SUBROUTINE_BRANCH ||
                        op_q == OP_POINTER_SUBROUTINE_BRANCH ||
                        op_q == OP_EXTENDED_POINTER_SUBROUTINE_BRANCH ||
                        op_q == OP_ABSOLUTE_SUBROUTINE_BRANCH) begin
                        // Low byte first, at SP, then SP moves down.
                        stk_we = 1'b1;
                        stk_wdata = ret_q[8*idx_q +: 8];
                        sp_d = sp_q - 16'h0001;
                        idx_d = idx_q + 2'd1;
                    end else if (op_q == OP_SUBROUTINE_EXIT || op_q == OP_INTERRUPT_EXIT) begin
                        // Reverse order: high byte comes back first.
                        stk_addr = sp_q + 16'h0001;
                        stk_re = 1'b1;
                        tgt_d[8*(2'(`FCD_RA_BYTES - 1) - idx_q) +: 8] = stk_rdata;
                        sp_d = sp_q + 16'h0001;
                        idx_d = idx_q + 2'd1;
                    end
                end
                if (cnt_q == 3'd0) begin
                    pc_d = tgt_q[PC_W-1:0];
                    done = 1'b1;
                    st_d = ST_IDLE;
                    if (op_q == OP_INTERRUPT_EXIT) begin
                        sr_d[`FCD_SR_I] = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q - 3'd1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // A frozen block must not write the stack or report completion.
        if (!ce) begin
            stk_we = 1'b0;
            stk_re = 1'b0;
            done = 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            op_q <= OP_NONE;
            cnt_q <= 3'h0;
            idx_q <= 2'h0;
            tgt_q <= '0;
            ret_q <= '0;
            pc_q <= '0;
            sr_q <= 8'h00;
            sp_q <= SP_RESET;
        end else if (ce) begin
            st_q <= st_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            tgt_q <= tgt_d;
            ret_q <= ret_d;
            pc_q <= pc_d;
            sr_q <= sr_d;
            sp_q <= sp_d;
        end
    end

endmodule : fcd_core

`default_nettype wire

// *** sim/fcd_core_properties.sv ***
/*
 * Concurrent checks on the ports of fcd_core, bound into every instance.
 * Assumes a single clock domain and the reset of that domain.
 */
`timescale 1ns/1ps
`default_nettype none

module fcd_core_props import fcd_pkg::*; #(
    parameter int PC_W = 22
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire fcd_op_t op,
    input wire logic [7:0] rd_val,
    input wire logic [7:0] rr_val,
    input wire logic [11:0] rel_ofs,
    input wire logic [2:0] bit_sel,
    input wire logic next_two_word,
    input wire logic [15:0] ptr_val,
    input wire logic [7:0] extended_pointer_prefix,
    input wire logic [PC_W-1:0] abs_target,
    input wire logic busy,
    input wire logic done,
    input wire logic [PC_W-1:0] pc_q,
    input wire logic [7:0] status_register,
    input wire logic [15:0] sp_q,
    input wire logic stk_we
);
    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    logic take; // An operation is accepted at this edge.
    assign take = start && !busy && ce;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    a_rel_call_len: assert property (take && op == OP_RELATIVE_SUBROUTINE_BRANCH |->
        !done ##1 (busy && !done)[*2] ##1 done) else $error("relative call length wrong");
    a_ptr_call_pc: assert property (take && op == OP_POINTER_SUBROUTINE_BRANCH |->
        ##4 pc_q == PC_W'($past(ptr_val, 4))) else $error("pointer call target wrong");
    a_ext_call_pc: assert property (take && op == OP_EXTENDED_POINTER_SUBROUTINE_BRANCH |->
        ##4 pc_q == PC_W'({$past(extended_pointer_prefix, 4), $past(ptr_val, 4)}))
        else $error("extended call target wrong");
    a_abs_call_pc: assert property (take && op == OP_ABSOLUTE_SUBROUTINE_BRANCH |->
        ##5 pc_q == $past(abs_target, 5)) else $error("absolute call target wrong");
    a_iexit_sets_i: assert property (take && op == OP_INTERRUPT_EXIT |->
        ##5 status_register[7]) else $error("interrupt exit left I clear");
    a_push_dec_sp: assert property (stk_we |=> sp_q == $past(sp_q) - 16'h1)
        else $error("push did not decrement sp");
    a_cse_skip_two: assert property (take && op == OP_COMPARE_SKIP_EQUAL &&
        rd_val == rr_val && !next_two_word |-> ##2 pc_q == PC_W'($past(pc_q, 2) + 2) &&
        status_register == $past(status_register, 2)) else $error("equal skip wrong");
    a_branch_taken: assert property (take && op == OP_BRANCH_FLAG_ONE &&
        status_register[bit_sel] |-> ##2 pc_q ==
        PC_W'($past(pc_q, 2) + PC_W'($signed($past(rel_ofs, 2))) + 1))
        else $error("taken branch target wrong");
    a_cmp_one_cycle: assert property (take && op inside {OP_COMPARE_REGS,
        OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE} |-> done ##1 !busy)
        else $error("compare not single cycle");

    // Covers for the main scenarios.
    c_call: cover property (take && op == OP_RELATIVE_SUBROUTINE_BRANCH);
    c_iexit: cover property (take && op == OP_INTERRUPT_EXIT);
    c_branch: cover property (take && op == OP_BRANCH_FLAG_ONE && status_register[bit_sel]);
endmodule : fcd_core_props

bind fcd_core fcd_core_props #(.PC_W(PC_W)) i_fcd_core_props (.ref_clk, .rst, .ce, .start,
    .op, .rd_val, .rr_val, .rel_ofs, .bit_sel, .next_two_word, .ptr_val,
    .extended_pointer_prefix, .abs_target, .busy, .done, .pc_q, .status_register, .sp_q,
    .stk_we);

`default_nettype wire

// *** sim/test_flow_and_compare_decode.sv ***
/*
 * Self-checking bench for fcd_core: calls, exits, compares, skips, branches.
 * Assumes the bench models the byte-wide stack memory itself.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module test_flow_and_compare_decode import fcd_pkg::*; ;
    // -------------------------------------------------------------------
    // Stimulus and observed signals
    // -------------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1; // Dropped only by the freeze test.
    logic start = 1'b0;
    fcd_op_t op = OP_NONE;
    logic [7:0] rd_val = 8'h00, rr_val = 8'h00, imm_val = 8'h00, io_val = 8'h00;
    logic [7:0] extended_pointer_prefix = 8'h00;
    logic [11:0] rel_ofs = 12'h000;
    logic [2:0] bit_sel = 3'h0;
    logic next_two_word = 1'b0;
    logic [15:0] ptr_val = 16'h0000;
    logic [21:0] abs_target = 22'h0;
    logic [7:0] stk_rdata, status_register, stk_wdata;
    logic busy, done, stk_we, stk_re;
    logic [21:0] pc_q;
    logic [15:0] sp_q, stk_addr;
    logic [7:0] mem [0:65535]; // Stack memory, unwritten bytes stay unknown.
    int fails = 0;
    int comparisons = 0;

    always #10 ref_clk = ~ref_clk;

    // The stack writes on the clock and reads combinationally.
    always @(posedge ref_clk) if (stk_we) mem[stk_addr] <= stk_wdata;
    // Outside a read the data lines show junk so a stray sample is caught.
    assign stk_rdata = stk_re ? mem[stk_addr] : 8'hA5;

    fcd_core i_fcd_core (.ref_clk(ref_clk), .rst(rst), .ce(ce), .start(start), .op(op),
        .rd_val(rd_val), .rr_val(rr_val), .imm_val(imm_val), .rel_ofs(rel_ofs),
        .bit_sel(bit_sel), .io_val(io_val), .next_two_word(next_two_word), .ptr_val(ptr_val),
        .extended_pointer_prefix(extended_pointer_prefix), .abs_target(abs_target),
        .stk_rdata(stk_rdata), .busy(busy), .done(done), .pc_q(pc_q),
        .status_register(status_register), .sp_q(sp_q), .stk_addr(stk_addr),
        .stk_we(stk_we), .stk_wdata(stk_wdata), .stk_re(stk_re));

    // -------------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------------
    // Issue one operation, count its cycles up to done, then check the PC.
    task automatic run(input fcd_op_t o, input int cyc, input logic [21:0] exp_pc);
        int n;
        n = 1;
        @(posedge ref_clk);
        #1 op = o;
        start = 1'b1;
        #1;
        while (done !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1 start = 1'b0;
            #1 n++;
        end
        @(posedge ref_clk);
        #1 start = 1'b0;
        `CHK(n, cyc)
        `CHK(pc_q, exp_pc)
    endtask : run

    // A call, a look at the pushed bytes, then the matching exit.
    task automatic call_ret(input fcd_op_t o, input int cyc, input logic [21:0] tgt,
                            input logic [21:0] ret, input fcd_op_t ex);
        logic [15:0] sp0;
        logic [7:0] sr0;
        sp0 = sp_q;
        sr0 = status_register;
        run(o, cyc, tgt);
        `CHK({mem[sp0-16'h2], mem[sp0-16'h1], mem[sp0]}, {2'h0, ret})
        `CHK(sp_q, sp0 - 16'h3)
        `CHK(status_register, sr0)
        run(ex, 5, ret);
        `CHK(sp_q, sp0)
        `CHK(status_register, sr0 | ((ex == OP_INTERRUPT_EXIT) ? 8'h80 : 8'h00))
    endtask : call_ret

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_calls();
        rel_ofs = 12'hFF0;
        call_ret(OP_RELATIVE_SUBROUTINE_BRANCH, 4, pc_q - 22'hF, pc_q + 22'h1, OP_SUBROUTINE_EXIT);
        ptr_val = 16'hBEEF;
        call_ret(OP_POINTER_SUBROUTINE_BRANCH, 4, 22'hBEEF, pc_q + 22'h1, OP_INTERRUPT_EXIT);
        extended_pointer_prefix = 8'h2A;
        ptr_val = 16'h1234;
        call_ret(OP_EXTENDED_POINTER_SUBROUTINE_BRANCH, 4, 22'h2A1234, pc_q + 22'h1, OP_SUBROUTINE_EXIT);
        abs_target = 22'h3FFFFE;
        call_ret(OP_ABSOLUTE_SUBROUTINE_BRANCH, 5, 22'h3FFFFE, pc_q + 22'h2, OP_SUBROUTINE_EXIT);
        $display("Test calls done");
    endtask : t_calls

    // Borrow chaining: the second compare sees C set and Z clear.
    task automatic t_compares();
        fcd_op_t ops [4] = '{OP_COMPARE_REGS, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE,
            OP_COMPARE_REGS};
        logic [7:0] va [4] = '{8'h10, 8'h20, 8'h80, 8'h55};
        logic [7:0] vb [4] = '{8'h20, 8'h1F, 8'h01, 8'h55};
        logic [7:0] sr [4] = '{8'h85, 8'hA0, 8'hA8, 8'h82};
        for (int i = 0; i < 4; i++) begin
            rd_val = va[i];
            rr_val = vb[i];
            imm_val = vb[i];
            run(ops[i], 1, pc_q + 22'h1);
            `CHK(status_register, sr[i])
        end
        $display("Test compares done");
    endtask : t_compares

    // Status holds I and Z set, C clear from the compares above.
    task automatic t_branch();
        bit_sel = 3'h1;
        rel_ofs = 12'h005;
        run(OP_BRANCH_FLAG_ONE, 2, pc_q + 22'h6);
        bit_sel = 3'h0;
        run(OP_BRANCH_FLAG_ONE, 1, pc_q + 22'h1);
        bit_sel = 3'h7;
        rel_ofs = 12'hFFE;
        run(OP_BRANCH_FLAG_ONE, 2, pc_q - 22'h1);
        `CHK(status_register, 8'h82)
        $display("Test branch done");
    endtask : t_branch

    task automatic t_skips();
        fcd_op_t ops [11] = '{OP_COMPARE_SKIP_EQUAL, OP_COMPARE_SKIP_EQUAL,
            OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_CLEAR,
            OP_SKIP_REG_BIT_ONE, OP_SKIP_REG_BIT_ONE, OP_SKIP_IO_BIT_CLEAR,
            OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_ONE, OP_SKIP_IO_BIT_ONE};
        logic [7:0] va [11] = '{8'h3C, 8'h3C, 8'h3C, 8'hF7, 8'h08, 8'h80, 8'h7F, 8'hFE, 8'h01,
            8'h40, 8'hBF};
        logic [2:0] bs [11] = '{3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h7, 3'h7, 3'h0, 3'h0, 3'h6, 3'h6};
        logic tw [11] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        int adv [11] = '{2, 1, 3, 3, 1, 2, 1, 2, 1, 3, 1};
        for (int i = 0; i < 11; i++) begin
            rd_val = va[i];
            rr_val = (i == 1) ? 8'h3D : va[i];
            io_val = va[i];
            bit_sel = bs[i];
            next_two_word = tw[i];
            run(ops[i], adv[i], pc_q + 22'(adv[i]));
            `CHK(status_register, 8'h82)
        end
        $display("Test skips done");
    endtask : t_skips

    // Freezing an exit mid-way holds its pops; it resumes where it stopped.
    task automatic t_freeze();
        logic [21:0] ra;
        logic [15:0] sp0;
        int n;
        ra = pc_q + 22'h1;
        sp0 = sp_q;
        ptr_val = 16'h0ACE;
        n = 0;
        run(OP_POINTER_SUBROUTINE_BRANCH, 4, 22'h0ACE);
        @(posedge ref_clk);
        #1 op = OP_SUBROUTINE_EXIT;
        start = 1'b1;
        @(posedge ref_clk);
        #1 start = 1'b0;
        ce = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 `CHK({busy, done, stk_re, sp_q, pc_q}, {3'b100, sp0 - 16'h3, 22'h0ACE})
        ce = 1'b1;
        // The frozen first pop is redone, so three more cycles reach done.
        while (done !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1 n++;
        end
        @(posedge ref_clk);
        #1 `CHK(n, 3)
        `CHK({sp_q, pc_q, status_register}, {sp0, ra, 8'h82})
        $display("Test freeze done");
    endtask : t_freeze

    // -------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // -------------------------------------------------------------------
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // About 110 cycles of work; 2000 cycles, some eighteen times that, means a hang.
    initial begin
        #40000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        #1 rst = 1'b0;
        `CHK(pc_q, 22'h0)
        `CHK(sp_q, 16'hFFFF)
        `CHK(status_register, 8'h00)
        t_calls();
        t_compares();
        t_branch();
        t_skips();
        t_freeze();
        give_verdict();
    end
endmodule : test_flow_and_compare_decode

`default_nettype wire
